// >>> src/rivp_pkg.sv
// Purpose: shared constants and types for the reset and interrupt vector placement block
// Assumes: word-addressed program memory, one word per vector slot
// Notes:   slot offsets are relative to the active vector base
package rivp_pkg;

   // program address width and default boot section start
   localparam int unsigned ADDR_W       = 12;
   localparam logic [11:0] BOOT_START   = 12'hc00;
   localparam int unsigned NUM_SRC      = 18;

   // reset slot and first interrupt slot offsets
   localparam logic [11:0] RESET_OFFSET = 12'h000;
   localparam logic [11:0] FIRST_OFFSET = 12'h001;

   // per-source offsets, index 0 is external request zero
   localparam logic [11:0] OFS_EXT0     = 12'h001;
   localparam logic [11:0] OFS_EXT1     = 12'h002;
   localparam logic [11:0] OFS_T2_CMP   = 12'h003;
   localparam logic [11:0] OFS_T2_OVF   = 12'h004;
   localparam logic [11:0] OFS_T1_CAP   = 12'h005;
   localparam logic [11:0] OFS_T1_CMPA  = 12'h006;
   localparam logic [11:0] OFS_T1_CMPB  = 12'h007;
   localparam logic [11:0] OFS_T1_OVF   = 12'h008;
   localparam logic [11:0] OFS_T0_OVF   = 12'h009;
   localparam logic [11:0] OFS_SER_DONE = 12'h00a;
   localparam logic [11:0] OFS_RX_DONE  = 12'h00b;
   localparam logic [11:0] OFS_TX_EMPTY = 12'h00c;
   localparam logic [11:0] OFS_TX_DONE  = 12'h00d;
   localparam logic [11:0] OFS_CONV     = 12'h00e;
   localparam logic [11:0] OFS_NV_RDY   = 12'h00f;
   localparam logic [11:0] OFS_COMP     = 12'h010;
   localparam logic [11:0] OFS_TWO_WIRE = 12'h011;
   localparam logic [11:0] OFS_PS_RDY   = 12'h012;

   // fuse encoding: programmed reads as zero
   localparam logic        FUSE_PROGRAMMED = 1'b0;

   // change window length in cycles and counter reset value
   localparam logic [2:0]  CHANGE_WINDOW = 3'h4;
   localparam logic [2:0]  CNT_RESET     = 3'h0;

   // reset values of control bits
   localparam logic        SELECT_RESET  = 1'b0;
   localparam logic        CHANGE_RESET  = 1'b0;

   // change sequence state, gray coded along idle -> armed -> hold
   typedef enum logic [1:0] {
      RIVP_IDLE  = 2'b00,
      RIVP_ARMED = 2'b01,
      RIVP_HOLD  = 2'b11
   } rivp_seq_t;

endpackage : rivp_pkg

// >>> src/rivp_sync.sv
// Purpose: two-flop synchroniser for a level coming from outside the clock domain
// Assumes: input may change at any time
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module rivp_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic meta;
      logic stable;
   } rivp_sync_t;

   rivp_sync_t st;
   rivp_sync_t next_st;

   // shift the level through two stages
   always_comb begin
      next_st        = st;
      if (ce) begin
         next_st.meta   = async_in;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;

endmodule : rivp_sync

// >>> src/rivp_prio.sv
// Purpose: lowest-slot-first selection among accepted pending sources
// Assumes: bit 0 is the lowest slot
// Notes:   purely combinational
`timescale 1ns/1ps
module rivp_prio #(
   parameter int unsigned N = 18
) (
   input  wire logic [N-1:0] pending,
   output logic              any,
   output logic [4:0]        index
);

   logic [N:0]   found;
   logic [4:0]   pick [N:0];

   assign found[0] = 1'b0;
   assign pick[0]  = 5'h00;

   // scan from the top down so the lowest set bit wins
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_scan
         assign found[g+1] = found[g] | pending[N-1-g];
         assign pick[g+1]  = pending[N-1-g] ? 5'(N-1-g) : pick[g];
      end
   endgenerate

   assign any   = found[N];
   assign index = pick[N];

endmodule : rivp_prio

// >>> src/rivp_top.sv
// Purpose: produce reset and interrupt vector addresses for the core program counter
// Assumes: core gives a write strobe with the two control bits, and an ack per taken vector
// Notes:   interrupt arbitration beyond lowest-slot-first is outside this block
//
// Overview of operation
// R1: any reset cause sends the program counter to the reset slot.
// R2: external requests zero and one use offsets 0x001 and 0x002.
// R3: timer events use offsets 0x003 through 0x009 in documented order.
// R4: serial done 0x00a; uart receive, empty, transmit 0x00b to 0x00d.
// R5: converter, nonvolatile, comparator, two-wire, program-store use 0x00e to 0x012.
// R6: programmed boot fuse moves reset entry to boot section start.
// R7: select bit set adds boot start to every interrupt offset.
// R8: fuse sets reset address only; select bit sets interrupt base only.
// R9: vector slots are plain memory; vectors fetched only on accepted interrupt.
// R10: reset entry and interrupt table placement are independent.
// R11: select changes only if written with change enable zero within four cycles.
// R12: change enable clears four cycles after set or on select write.
// R13: acceptance blocked from change enable set until after next instruction.
// R14: simultaneous pending sources vector to the lowest slot first.
// R15: each slot is one word, consecutive sources at consecutive addresses.
`timescale 1ns/1ps
module rivp_top #(
   parameter logic [11:0] BOOT_ADDR = rivp_pkg::BOOT_START
) (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           ce,
   input  wire logic                           reset_pin_n,
   input  wire logic                           power_on_reset,
   input  wire logic                           brown_out_reset,
   input  wire logic                           watchdog_reset,
   input  wire logic                           boot_reset_select_fuse,
   input  wire logic                           ctrl_write,
   input  wire logic                           ctrl_vector_table_select,
   input  wire logic                           ctrl_vector_change_enable,
   input  wire logic                           instr_done,
   input  wire logic [rivp_pkg::NUM_SRC-1:0]   irq_pending,
   input  wire logic                           irq_global_enable,
   input  wire logic                           vector_ack,
   output logic                                reset_load,
   output logic [rivp_pkg::ADDR_W-1:0]         reset_address,
   output logic                                vector_valid,
   output logic [rivp_pkg::ADDR_W-1:0]         vector_address,
   output logic [4:0]                          vector_source,
   output logic                                vector_table_select,
   output logic                                vector_change_enable,
   output logic                                irq_blocked
);

   // all state of the block except the pin synchroniser stages
   typedef struct packed {
      logic                        in_reset;
      logic                        reset_load;
      logic [11:0]                 reset_address;
      logic                        fuse;
      logic                        select;
      logic                        change;
      logic [2:0]                  cnt;
      rivp_pkg::rivp_seq_t         seq;
      logic                        blocked;
      logic                        vector_valid;
      logic [11:0]                 vector_address;
      logic [4:0]                  vector_source;
   } rivp_state_t;

   rivp_state_t st;
   rivp_state_t next_st;

   logic        pin_sync_n;
   logic        any_pending;
   logic [4:0]  pick;
   logic [11:0] offset_tab [rivp_pkg::NUM_SRC];
   logic        reset_cause;

   // external reset pin crosses into the clock domain
   rivp_sync u_pin_sync (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (reset_pin_n),
      .sync_out (pin_sync_n)
   );

   // lowest slot first among accepted sources
   rivp_prio #(
      .N (rivp_pkg::NUM_SRC)
   ) u_prio (
      .pending (irq_pending),
      .any     (any_pending),
      .index   (pick)
   );

   // slot offset table, one word per slot
   assign offset_tab[0]  = rivp_pkg::OFS_EXT0;      // R2
   assign offset_tab[1]  = rivp_pkg::OFS_EXT1;      // R2
   assign offset_tab[2]  = rivp_pkg::OFS_T2_CMP;    // R3
   assign offset_tab[3]  = rivp_pkg::OFS_T2_OVF;    // R3
   assign offset_tab[4]  = rivp_pkg::OFS_T1_CAP;    // R3
   assign offset_tab[5]  = rivp_pkg::OFS_T1_CMPA;   // R3
   assign offset_tab[6]  = rivp_pkg::OFS_T1_CMPB;   // R3
   assign offset_tab[7]  = rivp_pkg::OFS_T1_OVF;    // R3
   assign offset_tab[8]  = rivp_pkg::OFS_T0_OVF;    // R3
   assign offset_tab[9]  = rivp_pkg::OFS_SER_DONE;  // R4
   assign offset_tab[10] = rivp_pkg::OFS_RX_DONE;   // R4
   assign offset_tab[11] = rivp_pkg::OFS_TX_EMPTY;  // R4
   assign offset_tab[12] = rivp_pkg::OFS_TX_DONE;   // R4
   assign offset_tab[13] = rivp_pkg::OFS_CONV;      // R5
   assign offset_tab[14] = rivp_pkg::OFS_NV_RDY;    // R5
   assign offset_tab[15] = rivp_pkg::OFS_COMP;      // R5
   assign offset_tab[16] = rivp_pkg::OFS_TWO_WIRE;  // R5
   assign offset_tab[17] = rivp_pkg::OFS_PS_RDY;    // R5 R15

   // every reset cause funnels into one
   assign reset_cause = ~pin_sync_n | power_on_reset | brown_out_reset | watchdog_reset; // R1

   // next state
   always_comb begin
      next_st              = st;
      if (ce) begin
         // load pulse lasts one enabled cycle; a frozen clock holds it
         next_st.reset_load = 1'b0;
         if (reset_cause) begin
            // hold control at defaults while any cause is active
            next_st.in_reset      = 1'b1;
            next_st.select        = rivp_pkg::SELECT_RESET;
            next_st.change        = rivp_pkg::CHANGE_RESET;
            next_st.cnt           = rivp_pkg::CNT_RESET;
            next_st.seq           = rivp_pkg::RIVP_IDLE;
            next_st.blocked       = 1'b0;
            next_st.vector_valid  = 1'b0;
         end else if (st.in_reset) begin
            // on release, load the reset entry chosen by the fuse alone
            next_st.in_reset      = 1'b0;
            next_st.reset_load    = 1'b1;                                      // R1
            next_st.fuse          = boot_reset_select_fuse;
            next_st.reset_address = (boot_reset_select_fuse == rivp_pkg::FUSE_PROGRAMMED)
                                    ? BOOT_ADDR : rivp_pkg::RESET_OFFSET;      // R6 R8 R10
         end else begin
            // timed change sequence for the select bit
            case (st.seq)
               rivp_pkg::RIVP_IDLE: begin
                  if (ctrl_write && ctrl_vector_change_enable) begin
                     next_st.change  = 1'b1;                                   // R11
                     next_st.blocked = 1'b1;                                   // R13
                     next_st.cnt     = rivp_pkg::CHANGE_WINDOW;
                     next_st.seq     = rivp_pkg::RIVP_ARMED;
                  end
               end
               rivp_pkg::RIVP_ARMED: begin
                  if (ctrl_write && !ctrl_vector_change_enable) begin
                     next_st.select = ctrl_vector_table_select;                // R11
                     next_st.change = 1'b0;                                    // R12
                     next_st.cnt    = rivp_pkg::CNT_RESET;
                     next_st.seq    = rivp_pkg::RIVP_HOLD;
                  end else if (st.cnt == 3'h1) begin
                     next_st.change  = 1'b0;                                   // R12
                     next_st.blocked = 1'b0;                                   // R13
                     next_st.cnt     = rivp_pkg::CNT_RESET;
                     next_st.seq     = rivp_pkg::RIVP_IDLE;
                  end else begin
                     next_st.cnt = st.cnt - 3'h1;
                  end
               end
               rivp_pkg::RIVP_HOLD: begin
                  // keep blocking until the instruction after the write ends
                  if (instr_done) begin
                     next_st.blocked = 1'b0;                                   // R13
                     next_st.seq     = rivp_pkg::RIVP_IDLE;
                  end
               end
               default: begin
                  next_st.seq     = rivp_pkg::RIVP_IDLE;
                  next_st.change  = 1'b0;
                  next_st.blocked = 1'b0;
               end
            endcase

            // vector request: only accepted interrupts fetch from the table
            if (st.vector_valid) begin
               if (vector_ack) begin
                  next_st.vector_valid = 1'b0;
               end
            end else if (any_pending && irq_global_enable && !st.blocked) begin  // R9 R13
               next_st.vector_valid   = 1'b1;
               next_st.vector_source  = pick;                                  // R14
               next_st.vector_address = st.select
                                        ? 12'(BOOT_ADDR + offset_tab[pick])
                                        : offset_tab[pick];                    // R7 R8 R10 R15
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st               <= '0;
         st.in_reset      <= 1'b1;
         st.fuse          <= 1'b1;
         st.reset_address <= rivp_pkg::RESET_OFFSET;
         st.seq           <= rivp_pkg::RIVP_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign reset_load           = st.reset_load;
   assign reset_address        = st.reset_address;
   assign vector_valid         = st.vector_valid;
   assign vector_address       = st.vector_address;
   assign vector_source        = st.vector_source;
   assign vector_table_select  = st.select;
   assign vector_change_enable = st.change;
   assign irq_blocked          = st.blocked;

endmodule : rivp_top

// >>> tb/rivp_monitor.sv
// Purpose: concurrent checks on the vector placement block ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into rivp_top after the module
`timescale 1ns/1ps
module rivp_monitor #(
   parameter logic [11:0] BOOT_ADDR = rivp_pkg::BOOT_START
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        power_on_reset,
   input wire logic        brown_out_reset,
   input wire logic        watchdog_reset,
   input wire logic        boot_reset_select_fuse,
   input wire logic        ctrl_write,
   input wire logic        ctrl_vector_table_select,
   input wire logic        ctrl_vector_change_enable,
   input wire logic [17:0] irq_pending,
   input wire logic        irq_global_enable,
   input wire logic        vector_ack,
   input wire logic        reset_load,
   input wire logic [11:0] reset_address,
   input wire logic        vector_valid,
   input wire logic [11:0] vector_address,
   input wire logic [4:0]  vector_source,
   input wire logic        vector_table_select,
   input wire logic        vector_change_enable,
   input wire logic        irq_blocked
);
   logic        cause;
   logic [17:0] low_bit;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // same-domain reset causes and the lowest pending source as one-hot
   assign cause   = power_on_reset | brown_out_reset | watchdog_reset;
   assign low_bit = irq_pending & (~irq_pending + 18'h1);
   // a vector may be taken; a change sequence is armed
   sequence s_take; ce && !cause && irq_global_enable && (|irq_pending) && !irq_blocked && !vector_valid; endsequence
   sequence s_arm; ce && !cause && ctrl_write && ctrl_vector_change_enable && !vector_change_enable; endsequence
   // properties: reset entry, vector placement, change sequence, blocking
   property p_rst; reset_load |-> reset_address == (boot_reset_select_fuse ? 12'h000 : BOOT_ADDR); endproperty
   property p_addr;
      vector_valid |-> vector_address == (vector_table_select ? BOOT_ADDR : 12'h000) + 12'(vector_source) + 12'h001;
   endproperty
   property p_low; s_take |=> vector_valid && ((18'h1 << vector_source) == $past(low_bit)); endproperty
   property p_ack; ce && !cause && vector_valid && vector_ack |=> !vector_valid; endproperty
   property p_arm; s_arm and !irq_blocked |=> vector_change_enable && irq_blocked; endproperty
   property p_lapse;
      s_arm ##1 (ce && !cause && !ctrl_write) [*4] |=> !vector_change_enable && !irq_blocked && $stable(vector_table_select);
   endproperty
   property p_sel;
      ce && !cause && vector_change_enable && ctrl_write && !ctrl_vector_change_enable
         |=> !vector_change_enable && vector_table_select == $past(ctrl_vector_table_select);
   endproperty
   property p_block; ce && irq_blocked && !vector_valid |=> !vector_valid; endproperty
   a_rst: assert property (p_rst) else $error("reset address");
   a_addr: assert property (p_addr) else $error("vector address");
   a_low: assert property (p_low) else $error("not lowest source");
   a_ack: assert property (p_ack) else $error("vector kept after ack");
   a_arm: assert property (p_arm) else $error("arm missed");
   a_lapse: assert property (p_lapse) else $error("window end");
   a_sel: assert property (p_sel) else $error("select write");
   a_block: assert property (p_block) else $error("taken while blocked");
endmodule : rivp_monitor

bind rivp_top rivp_monitor #(.BOOT_ADDR(BOOT_ADDR)) u_mon (.clk, .rst, .ce, .power_on_reset, .brown_out_reset,
   .watchdog_reset, .boot_reset_select_fuse, .ctrl_write, .ctrl_vector_table_select, .ctrl_vector_change_enable,
   .irq_pending, .irq_global_enable, .vector_ack, .reset_load, .reset_address, .vector_valid, .vector_address,
   .vector_source, .vector_table_select, .vector_change_enable, .irq_blocked);

// >>> tb/rivp_core_model.sv
// Purpose: core-side model that takes presented vectors
// Assumes: a vector stands until acknowledged
// Notes:   ack_wait gives a prompt or a slow answer
`timescale 1ns/1ps
module rivp_core_model (
   input  wire logic       clk,
   input  wire logic       vector_valid,
   input  wire logic [3:0] ack_wait,
   output logic            vector_ack
);
   logic [3:0] waited = 4'h0;
   initial vector_ack = 1'b0;
   // one-cycle ack once the wait has run out
   always @(posedge clk) begin
      vector_ack <= 1'b0;
      if (vector_valid && !vector_ack && waited >= ack_wait) begin
         vector_ack <= 1'b1;
         waited     <= 4'h0;
      end else if (vector_valid && !vector_ack)
         waited <= waited + 4'h1;
   end
endmodule : rivp_core_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the vector placement block
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   integer model predicts every reset and vector address
`timescale 1ns/1ps
module testbench;
   localparam logic [11:0] BOOT = 12'h100;
   logic        clk, rst, ce, reset_pin_n, power_on_reset, brown_out_reset, watchdog_reset;
   logic        boot_reset_select_fuse, ctrl_write, ctrl_vector_table_select, ctrl_vector_change_enable;
   logic        instr_done, irq_global_enable, vector_ack, reset_load, vector_valid;
   logic        vector_table_select, vector_change_enable, irq_blocked;
   logic [17:0] irq_pending;
   logic [11:0] reset_address, vector_address;
   logic [4:0]  vector_source;
   logic [3:0]  ack_wait;
   int          n_fail, checks_done, seed, msel, i, k;

   rivp_top #(.BOOT_ADDR(BOOT)) DUT (.clk, .rst, .ce, .reset_pin_n, .power_on_reset, .brown_out_reset,
      .watchdog_reset, .boot_reset_select_fuse, .ctrl_write, .ctrl_vector_table_select,
      .ctrl_vector_change_enable, .instr_done, .irq_pending, .irq_global_enable, .vector_ack, .reset_load,
      .reset_address, .vector_valid, .vector_address, .vector_source, .vector_table_select,
      .vector_change_enable, .irq_blocked);
   rivp_core_model u_core (.clk, .vector_valid, .ack_wait, .vector_ack);

   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // verdict and end of run
   task automatic summarize();
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // count a comparison, report a miss at once
   task automatic chk(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask : chk

   // one edge, then let its updates land
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   // bounded wait for a level; running dry ends the run
   task automatic await(ref logic s, input logic v);
      for (k = 0; k < 40 && s !== v; k++) step();
      if (s !== v) begin
         chk(1'b0, "timeout");
         summarize();
      end
   endtask : await

   // reset entry after any release
   task automatic wait_load();
      #1;
      await(reset_load, 1'b1);
      chk(reset_address === (boot_reset_select_fuse ? 12'h000 : BOOT), "reset address");
      chk(vector_table_select === 1'b0 && vector_change_enable === 1'b0, "reset state");
      msel = 0;
   endtask : wait_load

   // chip reset held 20 cycles with a chosen fuse
   task automatic chip_reset(input logic f);
      @(posedge clk);
      rst <= 1'b1;
      boot_reset_select_fuse <= f;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_load();
   endtask : chip_reset

   // one reset cause for three cycles, 0 is the pin
   task automatic cause_reset(input int c);
      @(posedge clk);
      reset_pin_n <= (c != 0);
      power_on_reset <= (c == 1);
      brown_out_reset <= (c == 2);
      watchdog_reset <= (c == 3);
      repeat (3) @(posedge clk);
      {reset_pin_n, power_on_reset, brown_out_reset, watchdog_reset} <= 4'h8;
      wait_load();
   endtask : cause_reset

   // single control write
   task automatic wr(input logic s, input logic e);
      @(posedge clk);
      ctrl_write <= 1'b1;
      ctrl_vector_table_select <= s;
      ctrl_vector_change_enable <= e;
      step();
      ctrl_write <= 1'b0;
   endtask : wr

   // arm, write select, finish one instruction; sources wait meanwhile
   task automatic change(input logic s);
      wr(1'b0, 1'b1);
      chk(vector_change_enable === 1'b1 && irq_blocked === 1'b1, "arm");
      irq_pending <= 18'h3;
      wr(s, 1'b0);
      msel = s;
      chk(vector_table_select === s && vector_change_enable === 1'b0, "select write");
      step();
      chk(irq_blocked === 1'b1 && vector_valid === 1'b0, "block");
      instr_done <= 1'b1;
      step();
      instr_done <= 1'b0;
      irq_pending <= 18'h0;
      chk(irq_blocked === 1'b0, "unblock");
   endtask : change

   // raise sources, compare the vector with the lowest-slot model
   task automatic vec(input logic [17:0] p);
      int lo = 0;
      while (!p[lo]) lo++;
      @(posedge clk);
      irq_pending <= p;
      #1;
      await(vector_valid, 1'b1);
      irq_pending <= 18'h0;
      chk(vector_source === 5'(lo) && vector_address === 12'(msel * BOOT + lo + 1), "vector");
      await(vector_valid, 1'b0);
   endtask : vec

   // main sequence
   initial begin
      seed = 98877;
      {rst, ce, reset_pin_n, irq_global_enable} = 4'hf;
      {power_on_reset, brown_out_reset, watchdog_reset, boot_reset_select_fuse} = 4'h1;
      {ctrl_write, ctrl_vector_table_select, ctrl_vector_change_enable, instr_done} = 4'h0;
      irq_pending = 18'h0;
      ack_wait = 4'h0;
      chip_reset(1'b1);
      for (i = 0; i < 36; i++) begin
         if (i == 18) change(1'b1);
         vec(18'h1 << (i % 18));
      end
      for (i = 0; i < 30; i++) begin
         ack_wait <= 4'($random(seed));
         vec(18'($random(seed)) | 18'h20000);
      end
      wr(1'b0, 1'b1);
      repeat (3) step();
      chk(vector_change_enable === 1'b1, "window short");
      step();
      chk(vector_change_enable === 1'b0 && irq_blocked === 1'b0, "window end");
      wr(1'b0, 1'b0);
      chk(vector_table_select === 1'b1, "late write");
      vec(18'h4);
      irq_global_enable <= 1'b0;
      irq_pending <= 18'h1;
      repeat (5) step();
      chk(vector_valid === 1'b0, "taken while disabled");
      irq_global_enable <= 1'b1;
      ce <= 1'b0;
      repeat (5) step();
      chk(vector_valid === 1'b0, "taken while frozen");
      ce <= 1'b1;
      vec(18'h1);
      for (i = 0; i < 4; i++) begin
         change(1'b1);
         vec(18'h3);
         cause_reset(i);
      end
      chip_reset(1'b0);
      vec(18'h2);
      change(1'b1);
      vec(18'h20000);
      summarize();
   end
endmodule : testbench
